// ### src/rst_seq_map.vh
// constants for the reset and stop-recovery sequencer
// assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef RST_SEQ_MAP_VH
`define RST_SEQ_MAP_VH

// register byte offsets
`define OFS_RESET_CAUSE 12'hFF0
`define OFS_WDT_CTL 12'hFE0
`define OFS_OSC_CTL 12'hFD8
`define OFS_SEQ_CTL 12'hFDC
`define OFS_IRQ_STATUS 12'hFE4
`define OFS_IRQ_CLEAR 12'hFE8
`define OFS_IRQ_ENABLE 12'hFEC

// reset cause register fields
`define CAUSE_POR 7
`define CAUSE_WDT 5
`define CAUSE_EXT 4
`define CAUSE_VBO 3
`define CAUSE_RESET 8'h80

// watchdog control register fields, bits 7:4 are plain software bits
`define WCTL_EXT 0
`define WCTL_SMR 1
`define WCTL_WDT 2
`define WCTL_SW_MASK 8'hF0
`define WCTL_RESET 8'h00

// oscillator control register fields
`define OSC_IPO_EN 0
`define OSC_XTAL_EN 1
`define OSC_SEL_LO 2
`define OSC_SEL_HI 3
`define OSC_RESET 8'h01

// sequencer control register fields
`define SCTL_DBG_RST 0
`define SCTL_IND_EN 1
`define SCTL_RESET 8'h00

// interrupt status / clear / enable fields
`define IRQ_EXT 0
`define IRQ_INT 1
`define IRQ_SMR 2
`define IRQ_RESET 8'h00

// timing: reset timeout in ns, recovery holds in oscillator cycles
`define RST_TIMEOUT_NS 6600
`define CLK_PERIOD_NS 100
`define SMR_CYC_NO_XTAL 66
`define SMR_CYC_XTAL 5000
`define SETTLE_CYC 4

`endif

// ### src/sync_stage.v
// two-flop synchroniser for a group of asynchronous levels
// assumes clk is the system clock and rst is synchronous active high
`timescale 1ns/10ps
module sync_stage #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// asynchronous inputs and synchronised outputs
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_reg;

	// first flop feeds only the second
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // sync_stage

// ### src/reset_sequencer.v
// system reset control and stop-mode recovery sequencer
// assumes one 10 MHz clock, synchronous rst as power-on reset, Avalon-MM slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`include "rst_seq_map.vh"

// Function
// - a four-cycle low pulse on the reset pin always resets; three may. this design ignores the pin during stop-mode recovery.
// - the chip stays in reset as long as the reset pin is low. this design ignores the pin during stop-mode recovery.
// - past the timeout, reset ends on the first edge after pin release. this design ends it on the third edge, behind the synchroniser.
// - an external reset sets the external flag in watchdog control.
// - the reset pin is an open-drain low indicator during reset or when enabled. this design releases it after the external timeout and while settling.
// - internal resets pull the pin low until the reset delay has passed.
// - the debugger request bit resets the chip but not the debugger.
// - the debugger request bit clears itself during the reset it starts.
// - after a debugger reset the power-up flag in the cause register is set.
// - a stop instruction puts the device into stop mode.
// - recovery holds the cpu 66 cycles, or 5000 with crystal enabled.
// - recovery changes only watchdog control and oscillator control registers.
// - after recovery the internal oscillator is enabled and selected.
module reset_sequencer #(
	parameter SMR_XTAL_CYC = `SMR_CYC_XTAL
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// avalon-mm slave
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// reset pin, open drain
	input wire reset_pin_in_n,
	output reg reset_pin_out,
	output reg reset_pin_oe,
	// reset sources
	input wire brownout_n,
	input wire wdt_timeout,
	// stop mode
	input wire stop_instr,
	input wire wake_pin,
	output reg stop_mode,
	output reg cpu_hold,
	// reset to the chip, debugger excluded
	output reg sys_reset,
	// oscillator control
	output reg ipo_enable,
	output reg xtal_enable,
	output reg [1:0] clk_select,
	// interrupt
	output reg irq
);
	localparam [2:0] ST_RUN = 3'd0;
	localparam [2:0] ST_EXT = 3'd1;
	localparam [2:0] ST_INT = 3'd2;
	localparam [2:0] ST_SETTLE = 3'd3;
	localparam [2:0] ST_STOP = 3'd4;
	localparam [2:0] ST_SMR = 3'd5;

	localparam integer TIMEOUT_CYC_I = (`RST_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam [12:0] TIMEOUT_CYC = TIMEOUT_CYC_I[12:0];
	localparam integer SMR_SHORT_I = `SMR_CYC_NO_XTAL;
	localparam integer SETTLE_I = `SETTLE_CYC;
	localparam [12:0] SMR_SHORT = SMR_SHORT_I[12:0];
	localparam [12:0] SMR_LONG = SMR_XTAL_CYC[12:0];
	localparam [12:0] SETTLE = SETTLE_I[12:0];

	wire pin_n_s;
	wire bo_n_s;
	wire wake_s;
	reg [2:0] state_reg;
	reg [12:0] cnt_reg;
	reg [12:0] smr_len_reg;
	reg [7:0] cause_reg;
	reg [7:0] wctl_reg;
	reg [7:0] osc_reg;
	reg [7:0] sctl_reg;
	reg [7:0] irq_stat_reg;
	reg [7:0] irq_en_reg;
	reg [7:0] rd_next;
	reg [7:0] irq_set;
	reg [7:0] irq_clr;
	wire wr_go;
	wire [7:0] wbyte;
	wire int_src;

	// pin-facing levels synchronised first
	sync_stage #(
		.W(3),
		.RST_VAL(3'b110)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({reset_pin_in_n, brownout_n, wake_pin}),
		.q({pin_n_s, bo_n_s, wake_s})
	);

	assign wr_go = avs_write & ~avs_waitrequest;
	assign wbyte = avs_writedata[7:0];
	assign int_src = ~bo_n_s | wdt_timeout | sctl_reg[`SCTL_DBG_RST];

	// read mux for the register file
	always @* begin
		rd_next = 8'h00;
		case (avs_address)
			`OFS_RESET_CAUSE: rd_next = cause_reg;
			`OFS_WDT_CTL: rd_next = wctl_reg;
			`OFS_OSC_CTL: rd_next = osc_reg;
			`OFS_SEQ_CTL: rd_next = sctl_reg;
			`OFS_IRQ_STATUS: rd_next = irq_stat_reg;
			`OFS_IRQ_ENABLE: rd_next = irq_en_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// one wait cycle per access, data ready when waitrequest drops
	always @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			if (avs_waitrequest & (avs_read | avs_write)) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			if (avs_read & avs_waitrequest) begin
				avs_readdata <= {24'h00_0000, rd_next};
			end
		end
	end

	// interrupt events raised by the sequencer
	always @* begin
		irq_set = 8'h00;
		irq_clr = 8'h00;
		if (state_reg == ST_EXT && pin_n_s && cnt_reg >= TIMEOUT_CYC) begin
			irq_set[`IRQ_EXT] = 1'b1;
		end
		if (state_reg == ST_SETTLE && cnt_reg >= SETTLE) begin
			irq_set[`IRQ_INT] = 1'b1;
		end
		if (state_reg == ST_SMR && cnt_reg >= smr_len_reg) begin
			irq_set[`IRQ_SMR] = 1'b1;
		end
		if (wr_go && avs_address == `OFS_IRQ_CLEAR && avs_byteenable[0]) begin
			irq_clr = wbyte;
		end
	end

	// interrupt status, set wins over clear
	always @(posedge clk) begin
		if (rst) begin
			irq_stat_reg <= `IRQ_RESET;
			irq_en_reg <= `IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr_go && avs_address == `OFS_IRQ_ENABLE && avs_byteenable[0]) begin
				irq_en_reg <= wbyte;
			end
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// sequencer state, reset outputs and software registers
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_INT;
			cnt_reg <= 13'h0000;
			smr_len_reg <= SMR_SHORT;
			cause_reg <= `CAUSE_RESET; // power-on cause
			wctl_reg <= `WCTL_RESET;
			osc_reg <= `OSC_RESET;
			sctl_reg <= `SCTL_RESET;
			sys_reset <= 1'b1;
			cpu_hold <= 1'b0;
			stop_mode <= 1'b0;
			reset_pin_out <= 1'b0;
			reset_pin_oe <= 1'b1;
			ipo_enable <= 1'b1;
			xtal_enable <= 1'b0;
			clk_select <= 2'b00;
		end else begin
			reset_pin_out <= 1'b0;
			// register writes from software
			if (wr_go && avs_byteenable[0]) begin
				case (avs_address)
					`OFS_WDT_CTL: wctl_reg <= (wctl_reg & ~`WCTL_SW_MASK) | (wbyte & `WCTL_SW_MASK);
					`OFS_OSC_CTL: osc_reg <= wbyte;
					`OFS_SEQ_CTL: sctl_reg <= wbyte;
					default: ;
				endcase
			end
			case (state_reg)
				ST_RUN: begin
					sys_reset <= 1'b0;
					cpu_hold <= 1'b0;
					stop_mode <= 1'b0;
					cnt_reg <= 13'h0000;
					if (!pin_n_s) begin
						// one synchronised low sample is enough
						state_reg <= ST_EXT;
						sys_reset <= 1'b1;
						reset_pin_oe <= 1'b1;
					end else if (int_src) begin
						state_reg <= ST_INT;
						sys_reset <= 1'b1;
						reset_pin_oe <= 1'b1;
						cause_reg <= 8'h00;
						cause_reg[`CAUSE_VBO] <= ~bo_n_s;
						cause_reg[`CAUSE_WDT] <= wdt_timeout;
						cause_reg[`CAUSE_POR] <= sctl_reg[`SCTL_DBG_RST];
						wctl_reg[`WCTL_WDT] <= wdt_timeout;
						wctl_reg[`WCTL_EXT] <= 1'b0;
						wctl_reg[`WCTL_SMR] <= 1'b0;
						sctl_reg[`SCTL_DBG_RST] <= 1'b0;
					end else if (stop_instr) begin
						state_reg <= ST_STOP;
						stop_mode <= 1'b1;
						reset_pin_oe <= sctl_reg[`SCTL_IND_EN];
					end else begin
						reset_pin_oe <= sctl_reg[`SCTL_IND_EN];
					end
				end
				ST_EXT: begin
					// held while the pin is low, timeout then first release
					sys_reset <= 1'b1;
					// indicator only during the timeout, own drive would hide the far side's release
					reset_pin_oe <= (cnt_reg < TIMEOUT_CYC);
					if (cnt_reg < TIMEOUT_CYC) begin
						cnt_reg <= cnt_reg + 13'h0001;
					end
					if (pin_n_s && cnt_reg >= TIMEOUT_CYC) begin
						state_reg <= ST_RUN;
						sys_reset <= 1'b0;
						reset_pin_oe <= 1'b0;
						cause_reg <= 8'h00;
						cause_reg[`CAUSE_EXT] <= 1'b1;
						wctl_reg[`WCTL_EXT] <= 1'b1;
						wctl_reg[`WCTL_WDT] <= 1'b0;
						wctl_reg[`WCTL_SMR] <= 1'b0;
						osc_reg <= `OSC_RESET;
						sctl_reg <= `SCTL_RESET;
					end
				end
				ST_INT: begin
					// pin pulled low for the whole reset delay
					sys_reset <= 1'b1;
					reset_pin_oe <= 1'b1;
					sctl_reg[`SCTL_DBG_RST] <= 1'b0;
					osc_reg <= `OSC_RESET;
					cnt_reg <= cnt_reg + 13'h0001;
					if (cnt_reg >= TIMEOUT_CYC) begin
						state_reg <= ST_SETTLE;
						reset_pin_oe <= 1'b0;
						cnt_reg <= 13'h0000;
					end
				end
				ST_SETTLE: begin
					// own drive still echoing through the synchroniser
					sys_reset <= 1'b1;
					reset_pin_oe <= 1'b0;
					cnt_reg <= cnt_reg + 13'h0001;
					if (cnt_reg >= SETTLE) begin
						state_reg <= ST_RUN;
						sys_reset <= 1'b0;
						cnt_reg <= 13'h0000;
					end
				end
				ST_STOP: begin
					stop_mode <= 1'b1;
					reset_pin_oe <= sctl_reg[`SCTL_IND_EN];
					if (!pin_n_s) begin
						state_reg <= ST_EXT;
						stop_mode <= 1'b0;
						sys_reset <= 1'b1;
						reset_pin_oe <= 1'b1;
					end else if (wake_s) begin
						state_reg <= ST_SMR;
						stop_mode <= 1'b0;
						cpu_hold <= 1'b1;
						cnt_reg <= 13'h0000;
						smr_len_reg <= osc_reg[`OSC_XTAL_EN] ? SMR_LONG : SMR_SHORT;
					end
				end
				ST_SMR: begin
					// only watchdog and oscillator control change here
					cpu_hold <= 1'b1;
					cnt_reg <= cnt_reg + 13'h0001;
					osc_reg[`OSC_IPO_EN] <= 1'b1;
					osc_reg[`OSC_SEL_HI:`OSC_SEL_LO] <= 2'b00;
					wctl_reg[`WCTL_SMR] <= 1'b1;
					if (cnt_reg >= smr_len_reg - 13'h0001) begin
						state_reg <= ST_RUN;
						cpu_hold <= 1'b0;
						cnt_reg <= 13'h0000;
					end
				end
				default: begin
					state_reg <= ST_INT;
					cnt_reg <= 13'h0000;
				end
			endcase
			ipo_enable <= osc_reg[`OSC_IPO_EN];
			xtal_enable <= osc_reg[`OSC_XTAL_EN];
			clk_select <= osc_reg[`OSC_SEL_HI:`OSC_SEL_LO];
		end
	end
endmodule // reset_sequencer

// ### tb/reset_sequencer_monitor.sv
// port assertions for the reset sequencer
// assumes one clock domain, bound to every reset_sequencer
`timescale 1ns/10ps
module reset_sequencer_monitor #(
	parameter SMR_XTAL_CYC = 5000
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// pin and sources
	input wire reset_pin_in_n,
	input wire reset_pin_out,
	input wire reset_pin_oe,
	input wire wdt_timeout,
	input wire stop_instr,
	// sequencer outputs
	input wire stop_mode,
	input wire cpu_hold,
	input wire sys_reset,
	input wire ipo_enable,
	input wire [1:0] clk_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	int hold_cnt;
	// length of the current recovery hold
	always @(posedge clk) begin
		if (rst || !cpu_hold)
			hold_cnt <= 0;
		else
			hold_cnt <= hold_cnt + 1;
	end
	a_pin_low_resets: assert property (!reset_pin_in_n [*4] |-> sys_reset)
		else $error("pin low without reset");
	a_sync_two_edges: assert property ($fell(reset_pin_in_n) && !sys_reset && !wdt_timeout |=> !sys_reset [*2])
		else $error("pin used before synchroniser");
	a_out_low: assert property (reset_pin_out == 1'b0)
		else $error("pin driven high");
	a_oe_with_reset: assert property ($rose(sys_reset) |-> reset_pin_oe [*8])
		else $error("indicator not held");
	a_int_pulls_pin: assert property (wdt_timeout && !sys_reset && !stop_mode && !cpu_hold |=> sys_reset && reset_pin_oe)
		else $error("internal reset missed");
	a_stop_entry: assert property (stop_instr && !sys_reset && !stop_mode && !cpu_hold |=> stop_mode)
		else $error("stop not entered");
	a_hold_length: assert property ($fell(cpu_hold) |-> hold_cnt == 66 || hold_cnt == SMR_XTAL_CYC)
		else $error("recovery hold length wrong");
	a_osc_restored: assert property ($fell(cpu_hold) |-> ipo_enable && clk_select == 2'b00)
		else $error("oscillator not restored");
	c_recovery: cover property ($fell(cpu_hold));
	c_stop: cover property ($rose(stop_mode));
	c_ext: cover property ($rose(sys_reset) && !reset_pin_in_n);
endmodule // reset_sequencer_monitor

bind reset_sequencer reset_sequencer_monitor #(.SMR_XTAL_CYC(SMR_XTAL_CYC)) mon_u (.clk(clk), .rst(rst),
	.reset_pin_in_n(reset_pin_in_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
	.wdt_timeout(wdt_timeout), .stop_instr(stop_instr), .stop_mode(stop_mode), .cpu_hold(cpu_hold),
	.sys_reset(sys_reset), .ipo_enable(ipo_enable), .clk_select(clk_select));

// ### tb/board_reset_line.sv
// board reset line shared with other parts
// assumes a pull-up; any party may pull it low
`timescale 1ns/10ps
module board_reset_line (
	// device side
	input wire dev_oe,
	input wire dev_out,
	// other parts, pulse of four cycles or more
	input wire ext_low,
	// wired level
	output wire pin_n
);
	// open drain with pull-up
	assign pin_n = ((dev_oe && !dev_out) || ext_low) ? 1'b0 : 1'b1;
endmodule // board_reset_line

// ### tb/tb_reset_sequencer.sv
// bench for the reset sequencer
// assumes the board line model and the bound monitor
`timescale 1ns/10ps
module tb_reset_sequencer;
	localparam int XC = 20;
	logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ext_low = 1'b0;
	logic brownout_n = 1'b1, wdt_timeout = 1'b0, stop_instr = 1'b0, wake_pin = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic avs_waitrequest, reset_pin_in_n, reset_pin_out, reset_pin_oe, stop_mode, cpu_hold;
	logic sys_reset, ipo_enable, xtal_enable, irq;
	logic [1:0] clk_select;
	logic [7:0] q;
	int miscompares = 0, cmp_count = 0, n;
	reset_sequencer #(.SMR_XTAL_CYC(XC)) dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reset_pin_in_n(reset_pin_in_n),
		.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .brownout_n(brownout_n),
		.wdt_timeout(wdt_timeout), .stop_instr(stop_instr), .wake_pin(wake_pin), .stop_mode(stop_mode),
		.cpu_hold(cpu_hold), .sys_reset(sys_reset), .ipo_enable(ipo_enable), .xtal_enable(xtal_enable),
		.clk_select(clk_select), .irq(irq));
	board_reset_line line_u (.dev_oe(reset_pin_oe), .dev_out(reset_pin_out), .ext_low(ext_low),
		.pin_n(reset_pin_in_n));
	// clock
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// let an edge pass so a following call never reassigns in this time step
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	function automatic logic sv(input int s);
		case (s)
			0: return sys_reset;
			1: return reset_pin_oe;
			2: return cpu_hold;
			default: return stop_mode;
		endcase
	endfunction
	// edges until the chosen output shows v
	task automatic wt(input int s, input logic v, output int k);
		k = 0;
		while (sv(s) !== v && k < 9000) begin
			@(posedge clk);
			k++;
		end
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wt(0, 1'b0, n);
		rd(12'hFF0, 8'h80);
		bus(1'b1, 12'hFF0, 8'hFF, q);
		rd(12'hFF0, 8'h80);
		rd(12'hF00, 8'h00);
		rd(12'hFD8, 8'h01);
		bus(1'b1, 12'hFE8, 8'hFF, q);
		bus(1'b1, 12'hFEC, 8'h07, q);
		chk(irq, 1'b0);
		ext_low <= 1'b1;
		repeat (80) @(posedge clk);
		chk(sys_reset, 1'b1);
		ext_low <= 1'b0;
		wt(0, 1'b0, n);
		chk(n <= 4, 1'b1);
		rd(12'hFE0, 8'h01);
		rd(12'hFF0, 8'h10);
		chk(irq, 1'b1);
		bus(1'b1, 12'hFE8, 8'h01, q);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		ext_low <= 1'b1;
		repeat (4) @(posedge clk);
		ext_low <= 1'b0;
		wt(0, 1'b1, n);
		chk(n <= 4, 1'b1);
		wt(0, 1'b0, n);
		bus(1'b1, 12'hFDC, 8'h01, q);
		wt(0, 1'b1, n);
		chk(reset_pin_oe, 1'b1);
		wt(0, 1'b0, n);
		rd(12'hFDC, 8'h00);
		rd(12'hFF0, 8'h80);
		// watchdog then brown-out, one cycle each
		for (int i = 0; i < 2; i++) begin
			if (i == 0)
				wdt_timeout <= 1'b1;
			else
				brownout_n <= 1'b0;
			@(posedge clk);
			wdt_timeout <= 1'b0;
			brownout_n <= 1'b1;
			wt(1, 1'b1, n);
			wt(1, 1'b0, n);
			chk(n, 67);
			wt(0, 1'b0, n);
			rd(12'hFF0, i == 0 ? 8'h20 : 8'h08);
		end
		// stop and recovery, crystal on then off
		for (int x = 1; x >= 0; x--) begin
			bus(1'b1, 12'hFD8, x ? 8'h0E : 8'h0C, q);
			stop_instr <= 1'b1;
			@(posedge clk);
			stop_instr <= 1'b0;
			wt(3, 1'b1, n);
			chk(n, 1);
			chk({ipo_enable, xtal_enable, clk_select}, x ? 4'b0111 : 4'b0011);
			wake_pin <= 1'b1;
			wt(2, 1'b1, n);
			wake_pin <= 1'b0;
			wt(2, 1'b0, n);
			chk(n, x ? XC : 66);
			chk({ipo_enable, clk_select}, 3'b100);
			bus(1'b0, 12'hFD8, 8'h00, q);
			chk(q & 8'h0D, 8'h01);
			rd(12'hFEC, 8'h07);
			bus(1'b0, 12'hFE0, 8'h00, q);
			chk(q[1], 1'b1);
		end
		stop_test();
	end
	// watchdog against a hang
	initial begin
		#3000000;
		miscompares++;
		stop_test();
	end
endmodule // tb_reset_sequencer
